// *** port_five_regs.svh ***
// Register offsets, field positions, reset values for the five-bit port
// Assumes byte-wide register port with 8-bit addresses
`ifndef PORT_FIVE_REGS_SVH
`define PORT_FIVE_REGS_SVH
`define OFS_PIN_LATCH 8'h05
`define OFS_COMPARATOR 8'h1f
`define OFS_DIRECTION 8'h85
`define OFS_REFERENCE 8'h9f
`define RST_DIRECTION 5'h1f
`define RST_COMPARATOR 8'h00
`define RST_REFERENCE 8'h00
`define MODE_OFF 3'h7
`define MODE_OUTPUTS 3'h6
`define MODE_RESET 3'h0
`define CMP_MASK 8'hcf
`define REF_MASK 8'hef
`define REF_ENABLE_BIT 7
`define REF_PIN_BIT 6
`define PIN_OPEN_DRAIN 4
`define PIN_REFERENCE 2
`endif

// *** port_five_pkg.sv ***
// Types for the five-bit port
// Used by the port top module and its testbench
package port_five_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic write;
		logic read;
	} reg_req_t;
	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe;
	} pin_drive_t;
endpackage

// *** port_five.sv ***
// Five-bit general purpose port with comparator and reference sharing
// Assumes pin inputs synchronous to sys_clk; comparator results from analog
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "port_five_regs.svh"
module port_five
	import port_five_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire reg_req_t req,
	output logic [7:0] rdata,
	input wire logic [4:0] pin_in,
	output logic [4:0] pin_out,
	output logic [4:0] pin_oe,
	input wire logic first_comparator_result,
	input wire logic second_comparator_result,
	output logic timer_clock_pin_input,
	output logic [3:0] analog_input_enable,
	output logic analog_input_ground,
	output logic reference_power_on,
	output logic reference_pin_drive,
	output logic [5:0] reference_setting,
	output logic comparator_input_switch,
	output logic [2:0] comparator_mode
);
	logic [4:0] latch;
	logic [4:0] direction;
	logic [5:0] cmp_ctrl;
	logic [7:0] ref_ctrl;
	logic [3:0] cmp_in_sel;
	logic [4:0] pin_read;
	logic cmp_out_mode;
	logic [4:0] next_latch;
	logic [7:0] next_rdata;
	pin_drive_t next_drive;

	// Which pins act as comparator inputs in each mode
	always_comb begin
		unique case (cmp_ctrl[2:0])
		3'h7: cmp_in_sel = 4'h0;
		3'h5: cmp_in_sel = 4'ha;
		default: cmp_in_sel = 4'hf;
		endcase
	end
	assign cmp_out_mode = cmp_ctrl[2:0] == `MODE_OUTPUTS;

	// Comparator inputs read as zero; unused high bits zero
	assign pin_read = pin_in & ~{1'b0, cmp_in_sel};

	// A write takes the low five bits of the byte; bit operations are done by software
	// on the pin value it read, so the latch copies the modified pins.
	always_comb begin
		next_latch = latch;
		if (req.write && req.addr == `OFS_PIN_LATCH) begin
			next_latch = req.wdata[4:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			latch <= 5'h00;
		end else begin
			latch <= next_latch;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			direction <= `RST_DIRECTION;
			cmp_ctrl <= 6'h00;
			ref_ctrl <= `RST_REFERENCE;
		end else if (req.write) begin
			if (req.addr == `OFS_DIRECTION) begin
				direction <= req.wdata[4:0];
			end
			if (req.addr == `OFS_COMPARATOR) begin
				cmp_ctrl <= {2'h0, req.wdata[3:0]};
			end
			if (req.addr == `OFS_REFERENCE) begin
				ref_ctrl <= req.wdata & `REF_MASK;
			end
		end
	end

	// Read data valid exactly one cycle after the strobe
	always_comb begin
		next_rdata = 8'h00;
		if (req.read) begin
			unique case (req.addr)
			`OFS_PIN_LATCH: next_rdata = {3'h0, pin_read};
			`OFS_DIRECTION: next_rdata = {3'h0, direction};
			`OFS_COMPARATOR: next_rdata = {second_comparator_result,
				first_comparator_result, 2'h0, cmp_ctrl[3:0]};
			`OFS_REFERENCE: next_rdata = ref_ctrl;
			default: next_rdata = 8'h00;
			endcase
		end
	end

	always_comb begin
		next_drive.oe = ~direction;
		next_drive.out = latch;
		if (cmp_out_mode) begin
			next_drive.out[3] = first_comparator_result;
			next_drive.out[4] = second_comparator_result;
		end
		if (ref_ctrl[`REF_PIN_BIT] && ref_ctrl[`REF_ENABLE_BIT]) begin
			next_drive.oe[`PIN_REFERENCE] = 1'b0;
		end
		// Open drain: only enable while pulling low, output always zero
		next_drive.oe[`PIN_OPEN_DRAIN] = ~direction[4] &
			~next_drive.out[4];
		next_drive.out[`PIN_OPEN_DRAIN] = 1'b0;
	end

	// Read data stands for one cycle only, zero otherwise
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// Pin drive registered so pins never see decode glitches
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin_out <= 5'h00;
			pin_oe <= 5'h00;
		end else begin
			pin_out <= next_drive.out;
			pin_oe <= next_drive.oe;
		end
	end

	// Timer clock taken from the pin level, whatever its direction
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			timer_clock_pin_input <= 1'b0;
		end else begin
			timer_clock_pin_input <= pin_in[4];
		end
	end

	// Analog switch controls
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			analog_input_enable <= 4'h0;
			analog_input_ground <= 1'b1;
		end else begin
			analog_input_enable <= cmp_in_sel;
			// Grounding the inputs in reset mode saves supply current
			analog_input_ground <= cmp_ctrl[2:0] == `MODE_RESET;
		end
	end

	// Reference controls
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reference_power_on <= 1'b0;
			reference_pin_drive <= 1'b0;
			reference_setting <= 6'h00;
		end else begin
			reference_power_on <= ref_ctrl[`REF_ENABLE_BIT];
			reference_pin_drive <= ref_ctrl[`REF_PIN_BIT];
			reference_setting <= {ref_ctrl[5], 1'b0, ref_ctrl[3:0]};
		end
	end

	// Comparator mode copies
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			comparator_input_switch <= 1'b0;
			comparator_mode <= `MODE_RESET;
		end else begin
			comparator_input_switch <= cmp_ctrl[3];
			comparator_mode <= cmp_ctrl[2:0];
		end
	end

	a_rdata_port: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_PIN_LATCH |=> rdata[7:5] == 3'h0 &&
		rdata[4:0] == $past(pin_read))
		else $error("Port read mismatch");
	a_cmp_zero: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_PIN_LATCH && cmp_in_sel[0] |=>
		!rdata[0])
		else $error("Comparator input not zero");
	a_latch_write: assert property (@(posedge sys_clk) disable iff (reset)
		req.write && req.addr == `OFS_PIN_LATCH |=>
		latch == $past(req.wdata[4:0]))
		else $error("Latch not written");
	a_latch_hold: assert property (@(posedge sys_clk) disable iff (reset)
		!(req.write && req.addr == `OFS_PIN_LATCH) |=> $stable(latch))
		else $error("Latch changed");
	a_open_drain: assert property (@(posedge sys_clk) disable iff (reset)
		!pin_out[4])
		else $error("Pin four driven high");
	a_dir_hiz: assert property (@(posedge sys_clk) disable iff (reset)
		direction[1] |=> !pin_oe[1])
		else $error("Input pin driven");
	a_dir_drive: assert property (@(posedge sys_clk) disable iff (reset)
		!direction[0] ##1 !direction[0] |-> pin_oe[0] &&
		pin_out[0] == $past(latch[0]))
		else $error("Output pin not driven");
	a_dir_zero: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_DIRECTION |=> rdata[7:5] == 3'h0)
		else $error("Direction high bits");
	a_mode_off: assert property (@(posedge sys_clk) disable iff (reset)
		req.write && req.addr == `OFS_COMPARATOR && req.wdata[2:0] == 3'h7
		|=> ##1 analog_input_enable == 4'h0)
		else $error("Comparators not off");
	a_timer_pin: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=> timer_clock_pin_input == $past(pin_in[4]))
		else $error("Timer clock mismatch");

	// Register bus checks
	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (reset)
		!req.read |=>
		rdata == 8'h00)
		else $error("Read data not idle");

	a_dir_read: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_DIRECTION |=>
		rdata[4:0] == $past(direction))
		else $error("Direction read mismatch");

	a_dir_write: assert property (@(posedge sys_clk) disable iff (reset)
		req.write && req.addr == `OFS_DIRECTION |=>
		direction == $past(req.wdata[4:0]))
		else $error("Direction not written");

	a_dir_hold: assert property (@(posedge sys_clk) disable iff (reset)
		!(req.write && req.addr == `OFS_DIRECTION) |=>
		$stable(direction))
		else $error("Direction changed");

	a_cmp_write: assert property (@(posedge sys_clk) disable iff (reset)
		req.write && req.addr == `OFS_COMPARATOR |=>
		cmp_ctrl == {2'h0, $past(req.wdata[3:0])})
		else $error("Comparator control not written");

	a_cmp_read: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_COMPARATOR |=>
		rdata[5:4] == 2'h0)
		else $error("Comparator spare bits set");

	a_cmp_result: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_COMPARATOR |=>
		rdata[7:6] == $past({second_comparator_result,
		first_comparator_result}))
		else $error("Comparator result mismatch");

	a_ref_write: assert property (@(posedge sys_clk) disable iff (reset)
		req.write && req.addr == `OFS_REFERENCE |=>
		!ref_ctrl[4])
		else $error("Reference spare bit set");

	a_ref_read: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_REFERENCE |=>
		rdata == $past(ref_ctrl))
		else $error("Reference read mismatch");

	a_unmapped: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr != `OFS_PIN_LATCH &&
		req.addr != `OFS_DIRECTION && req.addr != `OFS_COMPARATOR &&
		req.addr != `OFS_REFERENCE |=>
		rdata == 8'h00)
		else $error("Unmapped read not zero");

	// Pin drive checks
	a_oe_follow: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=>
		pin_oe[1:0] == ~$past(direction[1:0]))
		else $error("Enable not from direction");

	a_out_follow: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=>
		pin_out[2:0] == $past(latch[2:0]))
		else $error("Output not from latch");

	a_pin3_out: assert property (@(posedge sys_clk) disable iff (reset)
		cmp_out_mode |=>
		pin_out[3] == $past(first_comparator_result))
		else $error("Pin three not comparator");

	a_pin3_latch: assert property (@(posedge sys_clk) disable iff (reset)
		!cmp_out_mode |=>
		pin_out[3] == $past(latch[3]))
		else $error("Pin three not latch");

	a_pin4_low: assert property (@(posedge sys_clk) disable iff (reset)
		!direction[4] && !latch[4] && !cmp_out_mode |=>
		pin_oe[4])
		else $error("Pin four not pulled low");

	a_pin4_release: assert property (@(posedge sys_clk) disable iff (reset)
		direction[4] |=>
		!pin_oe[4])
		else $error("Pin four driven as input");

	a_pin4_cmp: assert property (@(posedge sys_clk) disable iff (reset)
		cmp_out_mode && second_comparator_result |=>
		!pin_oe[4])
		else $error("Pin four pulled on high result");

	a_ref_pin: assert property (@(posedge sys_clk) disable iff (reset)
		ref_ctrl[7] && ref_ctrl[6] |=>
		!pin_oe[2])
		else $error("Pin two driven over reference");

	a_pin2_dir: assert property (@(posedge sys_clk) disable iff (reset)
		!(ref_ctrl[7] && ref_ctrl[6]) |=>
		pin_oe[2] == !$past(direction[2]))
		else $error("Pin two enable mismatch");

	a_cmp_in_oe: assert property (@(posedge sys_clk) disable iff (reset)
		cmp_in_sel[0] && !direction[0] |=>
		pin_oe[0])
		else $error("Analog pin ignores direction");

	a_out_pin4_src: assert property (@(posedge sys_clk) disable iff (reset)
		!direction[4] && latch[4] && !cmp_out_mode |=>
		!pin_oe[4])
		else $error("Pin four pulled on high latch");

	// Pin read and control copy checks
	a_read_zero_hi: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_PIN_LATCH && cmp_in_sel == 4'hf |=>
		rdata[3:0] == 4'h0)
		else $error("Analog pins not zero");

	a_cmp_zero_mode5: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_PIN_LATCH && cmp_ctrl[2:0] == 3'h5 |=>
		!rdata[1] && !rdata[3])
		else $error("Mode five pins not zero");

	a_mode_off_pins: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_PIN_LATCH && cmp_ctrl[2:0] == 3'h7 |=>
		rdata[3:0] == $past(pin_in[3:0]))
		else $error("Digital pins not read");

	a_read_pin4: assert property (@(posedge sys_clk) disable iff (reset)
		req.read && req.addr == `OFS_PIN_LATCH |=>
		rdata[4] == $past(pin_in[4]))
		else $error("Pin four read mismatch");

	a_mode5_pins: assert property (@(posedge sys_clk) disable iff (reset)
		cmp_ctrl[2:0] == 3'h5 |=>
		analog_input_enable == 4'ha)
		else $error("Mode five inputs wrong");

	a_mode_other: assert property (@(posedge sys_clk) disable iff (reset)
		cmp_ctrl[2:0] != 3'h7 && cmp_ctrl[2:0] != 3'h5 |=>
		analog_input_enable == 4'hf)
		else $error("Analog inputs wrong");

	a_ground: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=>
		analog_input_ground == ($past(cmp_ctrl[2:0]) == `MODE_RESET))
		else $error("Input ground mismatch");

	a_ref_copy: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=>
		reference_power_on == $past(ref_ctrl[7]) &&
		reference_pin_drive == $past(ref_ctrl[6]))
		else $error("Reference enables mismatch");

	a_ref_level: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=>
		reference_setting == {$past(ref_ctrl[5]), 1'b0,
		$past(ref_ctrl[3:0])})
		else $error("Reference setting mismatch");

	a_cmp_copy: assert property (@(posedge sys_clk) disable iff (reset)
		1'b1 |=>
		comparator_mode == $past(cmp_ctrl[2:0]) &&
		comparator_input_switch == $past(cmp_ctrl[3]))
		else $error("Comparator mode mismatch");
endmodule

// *** pins_model.sv ***
// Model of the circuits on the five port pins
// Assumes one clock; pin four has an external pull-up, others float
`timescale 1ns/1ps
module pins_model (
	input wire logic sys_clk,
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] ext,
	input wire logic [4:0] ext_en,
	output logic [4:0] pin_in
);
	logic [4:0] last = 5'h00;
	always_ff @(posedge sys_clk) begin
		last <= pin_in;
	end
	// A floating pin flips each cycle so a stale value never passes
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (pin_oe[i])
				pin_in[i] = (i == 4) ? 1'b0 : pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext[i];
			else
				pin_in[i] = (i == 4) ? 1'b1 : ~last[i];
		end
	end
endmodule

// *** tb_port_five.sv ***
// Testbench for the five-bit port: register accesses and pin checks
// Assumes port_five and pins_model are compiled before it
`timescale 1ns/1ps
`include "port_five_regs.svh"
module tb_port_five
	import port_five_pkg::*;
;
	logic sys_clk, reset, c1, c2, tclk, agnd;
	reg_req_t req;
	logic [7:0] rdata;
	logic [4:0] pin_in, pin_out, pin_oe, ext, ext_en;
	logic [3:0] aie;
	int n_mismatch, n_compared;
	port_five port_five_i (.sys_clk(sys_clk), .reset(reset), .req(req),
		.rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.first_comparator_result(c1), .second_comparator_result(c2),
		.timer_clock_pin_input(tclk), .analog_input_enable(aie),
		.analog_input_ground(agnd), .reference_power_on(),
		.reference_pin_drive(), .reference_setting(),
		.comparator_input_switch(), .comparator_mode());
	pins_model pins_model_i (.sys_clk(sys_clk), .pin_out(pin_out),
		.pin_oe(pin_oe), .ext(ext), .ext_en(ext_en), .pin_in(pin_in));
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge sys_clk);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge sys_clk);
		req <= '0;
		#1 chk(rdata, exp);
	endtask
	// Pins follow a write two edges later
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic complete_run();
		$display("Mismatches %0d, compares %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#50000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		reset = 1;
		req = '0;
		ext = 5'h0f;
		ext_en = 5'h0f;
		c1 = 0;
		c2 = 0;
		repeat (3) @(posedge sys_clk);
		reset <= 0;
		rd(`OFS_DIRECTION, 8'h1f);
		rd(`OFS_REFERENCE, 8'h00);
		chk({3'h0, pin_oe}, 8'h00);
		chk({7'h0, agnd}, 8'h01);
		chk({4'h0, aie}, 8'h0f);
		rd(`OFS_PIN_LATCH, 8'h10);
		c1 <= 1;
		rd(`OFS_COMPARATOR, 8'h40);
		wr(`OFS_COMPARATOR, 8'h07);
		settle();
		chk({4'h0, aie}, 8'h00);
		rd(`OFS_PIN_LATCH, 8'h1f);
		ext_en <= 5'h00;
		wr(`OFS_PIN_LATCH, 8'h0a);
		wr(`OFS_DIRECTION, 8'h00);
		settle();
		chk({3'h0, pin_oe}, 8'h1f);
		chk({3'h0, pin_out}, 8'h0a);
		rd(`OFS_PIN_LATCH, 8'h0a);
		chk({7'h0, tclk}, 8'h00);
		wr(`OFS_DIRECTION, 8'hff);
		settle();
		chk({3'h0, pin_oe}, 8'h00);
		rd(`OFS_DIRECTION, 8'h1f);
		wr(`OFS_DIRECTION, 8'h00);
		settle();
		chk({3'h0, pin_out}, 8'h0a);
		wr(`OFS_PIN_LATCH, 8'h15);
		settle();
		chk({3'h0, pin_oe}, 8'h0f);
		chk({3'h0, pin_out}, 8'h05);
		chk({7'h0, tclk}, 8'h01);
		wr(`OFS_REFERENCE, 8'hff);
		settle();
		chk({3'h0, pin_oe}, 8'h0b);
		rd(`OFS_REFERENCE, 8'hef);
		wr(`OFS_COMPARATOR, 8'h06);
		settle();
		chk({3'h0, pin_out}, 8'h0d);
		chk({3'h0, pin_oe}, 8'h1b);
		wr(8'h40, 8'h55);
		rd(8'h40, 8'h00);
		complete_run();
	end
endmodule
